// ==== dcsp_assertions.sv ====
// Port checker for the channel size and pointer block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
// ==========
// Checker
module dcsp_assertions (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        src_byte_i,
  input wire logic        dst_byte_i,
  input wire logic        pattern_mode_i,
  input wire logic        pattern_hit_i,
  input wire logic [15:0] src_byte_index_o,
  input wire logic [15:0] dst_byte_index_o,
  input wire logic        src_done_o,
  input wire logic        dst_done_flag_o,
  input wire logic        dst_half_flag_o,
  input wire logic        cell_done_flag_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_dst_wrap;
    dst_byte_i ##1 dst_byte_index_o == 16'h0000;
  endsequence
  a_upper_zero: assert property (rd_i |=> rdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not idle");
  a_dptr_step: assert property (dst_byte_i |=> dst_byte_index_o == 16'h0000
    || dst_byte_index_o == $past(dst_byte_index_o) + 16'h0001) else $error("dst step");
  a_dptr_hold: assert property (!dst_byte_i |=> $stable(dst_byte_index_o))
    else $error("dst pointer moved");
  a_sptr_hold: assert property (!src_byte_i && !pattern_hit_i |=> $stable(src_byte_index_o))
    else $error("src pointer moved");
  a_sptr_clear: assert property (pattern_mode_i && pattern_hit_i |=> src_byte_index_o == 0)
    else $error("src pointer kept");
  a_done_wrap: assert property (s_dst_wrap |-> dst_done_flag_o)
    else $error("done flag missing");
  a_src_wrap: assert property (src_done_o |=> src_byte_index_o == 16'h0000)
    else $error("src no wrap");
  a_flag_keep: assert property (dst_done_flag_o && !wr_i |=> dst_done_flag_o)
    else $error("done flag lost");
  a_irq_cause: assert property (irq_o |-> dst_done_flag_o || dst_half_flag_o || cell_done_flag_o)
    else $error("irq without flag");
endmodule // dcsp_assertions

bind dcsp_regs dcsp_assertions i_dcsp_assertions (.*);

// ==== dcsp_engine.sv ====
// Transfer engine model that pulses byte strobes with random stalls.
// Assumes the same clock as the register block.
`timescale 1ns/1ps
// ==========
// Engine
module dcsp_engine (
  input  wire logic clk_i,
  output logic      src_byte_o,
  output logic      dst_byte_o,
  output logic      event_o
);
  initial {src_byte_o, dst_byte_o, event_o} = 3'h0;
  task automatic run(input bit dst, input int n);
    event_o <= 1'b1;
    repeat (n) begin
      @(posedge clk_i);
      event_o <= 1'b0;
      {dst_byte_o, src_byte_o} <= dst ? 2'h2 : 2'h1;
      @(posedge clk_i);
      {dst_byte_o, src_byte_o} <= 2'h0;
      repeat ($urandom_range(2)) @(posedge clk_i);
    end
  endtask
endmodule // dcsp_engine

// ==== dcsp_pkg.sv ====
// Package with register offsets, field layout, reset values and flag positions
// for the channel size and pointer register block.
// Assumes a 32-bit register port with word-aligned byte addresses.
package dcsp_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_SRC_SIZE  = 8'h00;
  localparam logic [7:0] OFS_DEST_SIZE = 8'h04;
  localparam logic [7:0] OFS_SRC_PTR   = 8'h08;
  localparam logic [7:0] OFS_DEST_PTR  = 8'h0c;
  localparam logic [7:0] OFS_CELL_SIZE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;

  // ==========================================================================
  // Field layout and reset values
  localparam int          FIELD_W    = 16;
  localparam logic [15:0] FIELD_RST  = 16'h0000;
  localparam int          FLAG_W     = 3;
  localparam int          FLAG_DONE  = 0;
  localparam int          FLAG_HALF  = 1;
  localparam int          FLAG_CELL  = 2;
  localparam logic [2:0]  FLAG_RST   = 3'h0;
  localparam logic [31:0] READ_UNMAP = 32'h0000_0000;

endpackage

// ==== dcsp_regs.sv ====
// Channel transfer-size and progress-pointer registers with completion flags.
// Assumes the transfer engine pulses byte strobes in the same clock domain.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// ============================================================================
// Operation
// - The destination size is a 16-bit byte count where zero stands for 65,536 bytes.
// - Bits 31 to 16 of the size and pointer registers always read as zero.
// - The source pointer is a read-only 16-bit index of the current source byte.
// - In pattern detect mode a pattern detect clears the source pointer to zero.
// - The destination pointer is a read-only 16-bit index unaffected by writes.
// - The cell size gives bytes moved per trigger event, zero meaning 65,536.
// - All size and pointer fields reset to zero; sizes are read/write, pointers read-only.
// - The source size uses the same 16-bit encoding, zero meaning 65,536 bytes.
// - Done rises when the destination pointer reaches the size, half at half the size.
// - Cell done rises once the programmed cell byte count has moved for the event.
module dcsp_regs (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        event_i,
  input  wire logic        src_byte_i,
  input  wire logic        dst_byte_i,
  input  wire logic        pattern_mode_i,
  input  wire logic        pattern_hit_i,
  output logic      [15:0] src_byte_index_o,
  output logic      [15:0] dst_byte_index_o,
  output logic             src_done_o,
  output logic             dst_done_flag_o,
  output logic             dst_half_flag_o,
  output logic             cell_done_flag_o,
  output logic             irq_o
);

  // ==========================================================================
  // Configuration state
  logic [15:0] src_byte_length;
  logic [15:0] dest_byte_length;
  logic [15:0] bytes_per_event;
  logic [2:0]  irq_mask;
  logic [15:0] next_src_byte_length;
  logic [15:0] next_dest_byte_length;
  logic [15:0] next_bytes_per_event;
  logic [2:0]  next_irq_mask;

  // ==========================================================================
  // Pointer and cell counter state
  logic [15:0] src_byte_index;
  logic [15:0] next_src_byte_index;
  logic [15:0] dst_byte_index;
  logic [15:0] next_dst_byte_index;
  logic [15:0] cell_count;
  logic [15:0] next_cell_count;

  // ==========================================================================
  // Flag state
  logic [2:0]  irq_stat;
  logic [2:0]  next_irq_stat;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clear;

  // ==========================================================================
  // Read data state
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // ==========================================================================
  // Decoded strobes and byte counts
  logic        wr_src_size;
  logic        wr_dest_size;
  logic        wr_cell_size;
  logic        wr_irq_mask;
  logic        wr_irq_stat;
  logic [16:0] dest_len_full;
  logic [16:0] src_len_full;
  logic [16:0] cell_len_full;
  logic [16:0] dest_len_half;
  logic [16:0] dst_after;
  logic [16:0] src_after;
  logic [16:0] cell_after;
  logic        dst_end;
  logic        dst_half_hit;
  logic        src_end;
  logic        cell_end;
  logic        src_clear;

  // ==========================================================================
  // Register write decode
  always_comb begin
    wr_src_size  = 1'b0;
    wr_dest_size = 1'b0;
    wr_cell_size = 1'b0;
    wr_irq_mask  = 1'b0;
    wr_irq_stat  = 1'b0;
    if (wr_i) begin
      if (addr_i == dcsp_pkg::OFS_SRC_SIZE) begin
        wr_src_size = 1'b1;
      end else if (addr_i == dcsp_pkg::OFS_DEST_SIZE) begin
        wr_dest_size = 1'b1;
      end else if (addr_i == dcsp_pkg::OFS_CELL_SIZE) begin
        wr_cell_size = 1'b1;
      end else if (addr_i == dcsp_pkg::OFS_IRQ_MASK) begin
        wr_irq_mask = 1'b1;
      end else if (addr_i == dcsp_pkg::OFS_IRQ_STAT) begin
        wr_irq_stat = 1'b1;
      end
      // Writes to the pointer offsets decode to nothing, so the pointers keep counting.
    end
  end

  // ==========================================================================
  // Byte counts and completion detection
  always_comb begin
    dest_len_full = {1'b0, dest_byte_length};
    if (dest_byte_length == 16'h0000) begin
      dest_len_full = 17'h1_0000;
    end
    src_len_full = {1'b0, src_byte_length};
    if (src_byte_length == 16'h0000) begin
      src_len_full = 17'h1_0000;
    end
    cell_len_full = {1'b0, bytes_per_event};
    if (bytes_per_event == 16'h0000) begin
      cell_len_full = 17'h1_0000;
    end
    dest_len_half = {1'b0, dest_len_full[16:1]};

    dst_after    = {1'b0, dst_byte_index} + 17'h0_0001;
    src_after    = {1'b0, src_byte_index} + 17'h0_0001;
    cell_after   = {1'b0, cell_count} + 17'h0_0001;
    dst_end      = dst_byte_i && (dst_after == dest_len_full);
    dst_half_hit = dst_byte_i && (dst_after == dest_len_half);
    src_end      = src_byte_i && (src_after == src_len_full);
    cell_end     = dst_byte_i && (cell_after == cell_len_full);
    src_clear    = pattern_mode_i && pattern_hit_i;
  end

  // ==========================================================================
  // Configuration registers
  always_comb begin
    next_src_byte_length  = src_byte_length;
    next_dest_byte_length = dest_byte_length;
    next_bytes_per_event  = bytes_per_event;
    next_irq_mask         = irq_mask;
    if (wr_src_size) begin
      next_src_byte_length = wdata_i[15:0];
    end
    if (wr_dest_size) begin
      next_dest_byte_length = wdata_i[15:0];
    end
    if (wr_cell_size) begin
      next_bytes_per_event = wdata_i[15:0];
    end
    if (wr_irq_mask) begin
      next_irq_mask = wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_byte_length  <= dcsp_pkg::FIELD_RST;
      dest_byte_length <= dcsp_pkg::FIELD_RST;
      bytes_per_event  <= dcsp_pkg::FIELD_RST;
      irq_mask         <= dcsp_pkg::FLAG_RST;
    end else begin
      src_byte_length  <= next_src_byte_length;
      dest_byte_length <= next_dest_byte_length;
      bytes_per_event  <= next_bytes_per_event;
      irq_mask         <= next_irq_mask;
    end
  end

  // ==========================================================================
  // Source pointer
  always_comb begin
    next_src_byte_index = src_byte_index;
    if (src_byte_i) begin
      next_src_byte_index = src_end ? 16'h0000 : src_after[15:0];
    end
    if (src_clear) begin
      next_src_byte_index = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_byte_index <= dcsp_pkg::FIELD_RST;
    end else begin
      src_byte_index <= next_src_byte_index;
    end
  end

  // ==========================================================================
  // Destination pointer
  always_comb begin
    next_dst_byte_index = dst_byte_index;
    if (dst_byte_i) begin
      next_dst_byte_index = dst_end ? 16'h0000 : dst_after[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dst_byte_index <= dcsp_pkg::FIELD_RST;
    end else begin
      dst_byte_index <= next_dst_byte_index;
    end
  end

  // ==========================================================================
  // Cell byte counter
  always_comb begin
    next_cell_count = cell_count;
    if (dst_byte_i) begin
      next_cell_count = cell_end ? 16'h0000 : cell_after[15:0];
    end
    if (event_i) begin
      next_cell_count = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cell_count <= dcsp_pkg::FIELD_RST;
    end else begin
      cell_count <= next_cell_count;
    end
  end

  // ==========================================================================
  // Interrupt flags
  always_comb begin
    flag_set                      = dcsp_pkg::FLAG_RST;
    flag_set[dcsp_pkg::FLAG_DONE] = dst_end;
    flag_set[dcsp_pkg::FLAG_HALF] = dst_half_hit;
    flag_set[dcsp_pkg::FLAG_CELL] = cell_end;
    flag_clear                    = dcsp_pkg::FLAG_RST;
    if (wr_irq_stat) begin
      flag_clear = wdata_i[2:0];
    end
  end

  for (genvar i = 0; i < dcsp_pkg::FLAG_W; i++) begin : g_flag
    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
      next_irq_stat[i] = irq_stat[i];
      if (flag_clear[i]) begin
        next_irq_stat[i] = 1'b0;
      end
      if (flag_set[i]) begin
        next_irq_stat[i] = 1'b1;
      end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        irq_stat[i] <= dcsp_pkg::FLAG_RST[i];
      end else begin
        irq_stat[i] <= next_irq_stat[i];
      end
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    next_rdata = dcsp_pkg::READ_UNMAP;
    if (rd_i) begin
      if (addr_i == dcsp_pkg::OFS_SRC_SIZE) begin
        next_rdata = {16'h0000, src_byte_length};
      end else if (addr_i == dcsp_pkg::OFS_DEST_SIZE) begin
        next_rdata = {16'h0000, dest_byte_length};
      end else if (addr_i == dcsp_pkg::OFS_SRC_PTR) begin
        next_rdata = {16'h0000, src_byte_index};
      end else if (addr_i == dcsp_pkg::OFS_DEST_PTR) begin
        next_rdata = {16'h0000, dst_byte_index};
      end else if (addr_i == dcsp_pkg::OFS_CELL_SIZE) begin
        next_rdata = {16'h0000, bytes_per_event};
      end else if (addr_i == dcsp_pkg::OFS_IRQ_STAT) begin
        next_rdata = {29'h0000_0000, irq_stat};
      end else if (addr_i == dcsp_pkg::OFS_IRQ_MASK) begin
        next_rdata = {29'h0000_0000, irq_mask};
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata <= dcsp_pkg::READ_UNMAP;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_o          = rdata;
  assign src_byte_index_o = src_byte_index;
  assign dst_byte_index_o = dst_byte_index;
  assign src_done_o       = src_end;
  assign dst_done_flag_o  = irq_stat[dcsp_pkg::FLAG_DONE];
  assign dst_half_flag_o  = irq_stat[dcsp_pkg::FLAG_HALF];
  assign cell_done_flag_o = irq_stat[dcsp_pkg::FLAG_CELL];
  assign irq_o            = |(irq_stat & irq_mask);

endmodule // dcsp_regs

// ==== tb_top.sv ====
// Self-checking bench for the channel size and pointer block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
// ==========
// Bench
module tb_top;
  logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, mode = 0, hit = 0, pend = 0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, r, exp_q[$];
  logic [15:0] sp, dp;
  logic        sb, db, ev, sd, dd, dh, cd, irq;
  int          n_fail = 0, checked = 0;
  always #5 clk_i = ~clk_i;
  dcsp_regs i_dcsp_regs (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .event_i(ev), .src_byte_i(sb), .dst_byte_i(db), .pattern_mode_i(mode),
    .pattern_hit_i(hit), .src_byte_index_o(sp), .dst_byte_index_o(dp), .src_done_o(sd),
    .dst_done_flag_o(dd), .dst_half_flag_o(dh), .cell_done_flag_o(cd), .irq_o(irq));
  dcsp_engine i_dcsp_engine (.clk_i, .src_byte_o(sb), .dst_byte_o(db), .event_o(ev));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (pend) chk("rdata", exp_q.pop_front(), rdata_o);
    pend <= rd_i;
  end
  task automatic close_out;
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    close_out;
  end
  initial begin
    void'($urandom(38));
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
    r = $urandom;
    wr(dcsp_pkg::OFS_DEST_SIZE, {r[31:16], 16'h0004});
    wr(dcsp_pkg::OFS_CELL_SIZE, {r[15:0], 16'h0002});
    wr(dcsp_pkg::OFS_SRC_SIZE, {r[23:8], 16'h0004});
    wr(dcsp_pkg::OFS_DEST_PTR, r);
    wr(dcsp_pkg::OFS_IRQ_MASK, 32'h7);
    rd(dcsp_pkg::OFS_DEST_SIZE, 32'h4);
    rd(dcsp_pkg::OFS_CELL_SIZE, 32'h2);
    rd(dcsp_pkg::OFS_DEST_PTR, 32'h0);
    i_dcsp_engine.run(1'b1, 4);
    rd(dcsp_pkg::OFS_DEST_PTR, 32'h0);
    rd(dcsp_pkg::OFS_IRQ_STAT, 32'h7);
    @(posedge clk_i) chk("irq", 32'h1, {31'h0, irq});
    chk("flags", 32'h7, {29'h0, cd, dh, dd});
    chk("pointers", 32'h0, {sp, dp});
    wr(dcsp_pkg::OFS_IRQ_STAT, 32'h7);
    wr(dcsp_pkg::OFS_IRQ_MASK, 32'h0);
    i_dcsp_engine.run(1'b1, 2);
    rd(dcsp_pkg::OFS_IRQ_STAT, 32'h6);
    @(posedge clk_i) chk("irq", 32'h0, {31'h0, irq});
    chk("flags", 32'h6, {29'h0, cd, dh, dd});
    chk("dst index", 32'h2, {16'h0, dp});
    i_dcsp_engine.run(1'b0, 3);
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      @(posedge clk_i) hit <= 1'b1;
      @(posedge clk_i) hit <= 1'b0;
      rd(dcsp_pkg::OFS_SRC_PTR, m ? 32'h0 : 32'h3);
    end
    i_dcsp_engine.run(1'b0, 4);
    rd(dcsp_pkg::OFS_SRC_PTR, 32'h0);
    repeat (3) @(posedge clk_i);
    close_out;
  end
endmodule // tb_top
